/* logic/imsh_consts.svh */
// Timing counts, codes and frame constants shared by both link ends
//
// How it works
// - Read bytes stream while master keeps acking
// - Read address wraps to zero past end
// - Master ends read with NACK then stop
// - Master sends 0000_1xxx after start for HS
// - Device never acknowledges the HS entry code
// - After that NACK both run high speed
// - Stop condition drops device out of HS
// - Sleep: start, F8, device word, restart, 86
// - Device acks sleep steps, then regulator stops
// - Asleep device still watches SCL and SDA
// - Wake: start plus device word, R/W ignored
// - Recovery starts at ninth SCL rise
// - Standby only after recovery; master waits too
// - Fixed read-only three byte identification
// - ID read: F8, device word, restart, F9
// - Master NACKs the last ID byte it asked for
// - Acked third ID byte restarts at first
// - Master only releases SDA, never drives high
// - Master may reset or retry after failure
// - Respond only to 1010 plus select pins
// - Eighth address bit: zero write, one read
`ifndef IMSH_CONSTS_SVH
`define IMSH_CONSTS_SVH

// ==========================================================
// Core clock and bus rates
`define IMSH_CLK_MHZ     250
`define IMSH_FM_KHZ      1000
`define IMSH_HS_KHZ      3400
// Quarter bit periods, rounded up so the rate never exceeds the limit
`define IMSH_QTR_FM      ((`IMSH_CLK_MHZ * 1000 + 4 * `IMSH_FM_KHZ - 1) / (4 * `IMSH_FM_KHZ))
`define IMSH_QTR_HS      ((`IMSH_CLK_MHZ * 1000 + 4 * `IMSH_HS_KHZ - 1) / (4 * `IMSH_HS_KHZ))

// ==========================================================
// Regulator recovery time
`define IMSH_REC_TIME_NS 1000
`define IMSH_REC_CYC     ((`IMSH_REC_TIME_NS * `IMSH_CLK_MHZ + 999) / 1000)

// ==========================================================
// Frame codes
`define IMSH_DEV_TYPE    4'ha
`define IMSH_HS_CODE     5'h01
`define IMSH_HS_BYTE     8'h08
`define IMSH_RSV_ID      8'hf8
`define IMSH_SLEEP_CMD   8'h86
`define IMSH_ID_CMD      8'hf9
`define IMSH_ID_LAST     2'h2
`define IMSH_BIT_ACK     4'h8
`define IMSH_BIT_END     4'h9

`endif

/* logic/imsh_pkg.sv */
// Types shared by the memory slave and its bus master
`default_nettype none
package imsh_pkg;

  // ==========================================================
  // Slave protocol states
  typedef enum logic [3:0] {
    ps_idle, ps_dev, ps_ah, ps_al, ps_wr, ps_rd, ps_id, ps_rsv_dev,
    ps_rsv_wait, ps_rsv_cmd, ps_ign, ps_sleep, ps_wake, ps_recov
  } imsh_pst_t;

  // ==========================================================
  // Master commands and micro-operations
  typedef enum logic [2:0] {
    cmd_read, cmd_hs, cmd_sleep, cmd_wake, cmd_id, cmd_reset, cmd_write
  } imsh_cmd_t;

  typedef enum logic [2:0] {
    op_start, op_stop, op_wr, op_rd, op_clk9, op_wait, op_end
  } imsh_opk_t;

  typedef struct packed {
    imsh_opk_t  kind;
    logic [7:0] data;
    logic       ack_exp;
  } imsh_op_t;

endpackage
`default_nettype wire

/* logic/imsh_link.sv */
// Two-wire link joining the master end and the memory end
`timescale 1ns/1ps
`default_nettype none
interface imsh_link;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;

  // Open-drain wire: high unless an enabled driver pulls it down
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport dev  (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport host (output scl, output m_sda_o, output m_sda_oe, input sda);
endinterface
`default_nettype wire

/* logic/imsh_dev.sv */
// Memory slave end: reads, high speed, sleep and ID over the link
`timescale 1ns/1ps
`default_nettype none
`include "imsh_consts.svh"
module imsh_dev #(
  parameter int          REC_CYC = `IMSH_REC_CYC,
  parameter logic [23:0] ID_CODE = 24'h12_3456  // Arbitrary value
) (
  input  wire logic  core_clk,
  input  wire logic  rstn,
  imsh_link.dev      lnk,
  input  wire logic  chip_select_bit2,
  input  wire logic  chip_select_bit1,
  input  wire logic  chip_select_bit0,
  output logic       sleeping,
  output logic       regulator_on,
  output logic       hs_mode
);

  typedef struct packed {
    logic [2:0]        scl_s;
    logic [2:0]        sda_s;
    logic              scl_f;
    logic              sda_f;
    imsh_pkg::imsh_pst_t pst;
    logic [3:0]        bitn;
    logic              ackph;
    logic              mack;
    logic              tx;
    logic [7:0]        rxsh;
    logic [7:0]        txsh;
    logic [15:0]       addr;
    logic [1:0]        idx;
    logic              sleep_pend;
    logic              sda_oe;
    logic              sleep;
    logic              reg_on;
    logic              hs;
    logic [15:0]       rec_cnt;
    logic              mem_we;
    logic [15:0]       waddr;
    logic [7:0]        wdata;
  } imsh_dev_st_t;

  imsh_dev_st_t st_q;
  imsh_dev_st_t st_d;
  logic [7:0]   mem [0:65535];
  logic [2:0]   sel;
  logic         scl_n;
  logic         sda_n;
  logic         rise;
  logic         fall;
  logic         start_c;
  logic         stop_c;
  logic         ack;
  logic         match;

  assign sel   = {chip_select_bit2, chip_select_bit1, chip_select_bit0};
  assign match = (st_q.rxsh[7:4] == `IMSH_DEV_TYPE) && (st_q.rxsh[3:1] == sel);

  // ==========================================================
  // Protocol engine
  always_comb begin
    st_d        = st_q;
    ack         = 1'b0;
    st_d.mem_we = 1'b0;
    // pins sampled in every state, sleep included
    st_d.scl_s  = {st_q.scl_s[1:0], lnk.scl};
    st_d.sda_s  = {st_q.sda_s[1:0], lnk.sda};
    // A level counts once the second and third stages agree
    scl_n = (st_q.scl_s[1] == st_q.scl_s[2]) ? st_q.scl_s[2] : st_q.scl_f;
    sda_n = (st_q.sda_s[1] == st_q.sda_s[2]) ? st_q.sda_s[2] : st_q.sda_f;
    st_d.scl_f = scl_n;
    st_d.sda_f = sda_n;
    rise    = scl_n & ~st_q.scl_f;
    fall    = ~scl_n & st_q.scl_f;
    start_c = st_q.sda_f & ~sda_n & scl_n & st_q.scl_f;
    stop_c  = ~st_q.sda_f & sda_n & scl_n & st_q.scl_f;

    if (stop_c) begin
      st_d.hs     = 1'b0;
      st_d.bitn   = 4'h0;
      st_d.ackph  = 1'b0;
      st_d.tx     = 1'b0;
      st_d.sda_oe = 1'b0;
      case (st_q.pst)
        imsh_pkg::ps_sleep, imsh_pkg::ps_recov : st_d.pst = st_q.pst;
        imsh_pkg::ps_wake : st_d.pst = imsh_pkg::ps_sleep;
        default : st_d.pst = imsh_pkg::ps_idle;
      endcase
    end else if (start_c) begin
      st_d.bitn   = 4'h0;
      st_d.ackph  = 1'b0;
      st_d.tx     = 1'b0;
      st_d.sda_oe = 1'b0;
      case (st_q.pst)
        // start while asleep opens a wake frame
        imsh_pkg::ps_sleep, imsh_pkg::ps_wake : st_d.pst = imsh_pkg::ps_wake;
        imsh_pkg::ps_recov : st_d.pst = st_q.pst;
        imsh_pkg::ps_rsv_wait : st_d.pst = imsh_pkg::ps_rsv_cmd;
        default : st_d.pst = imsh_pkg::ps_dev;
      endcase
    end else if (rise) begin
      if (st_q.pst == imsh_pkg::ps_wake && st_q.bitn == `IMSH_BIT_ACK) begin
        // ninth rise from start begins recovery
        st_d.pst     = imsh_pkg::ps_recov;
        st_d.reg_on  = 1'b1;
        st_d.rec_cnt = 16'h0000;
      end
      if (st_q.bitn < `IMSH_BIT_ACK) begin
        st_d.rxsh = {st_q.rxsh[6:0], sda_n};
        st_d.txsh = {st_q.txsh[6:0], 1'b0};
        st_d.bitn = st_q.bitn + 4'h1;
      end else if (st_q.bitn == `IMSH_BIT_ACK) begin
        st_d.mack = sda_n;
        st_d.bitn = `IMSH_BIT_END;
      end
    end else if (fall) begin
      if (st_q.bitn == `IMSH_BIT_ACK && !st_q.ackph) begin
        st_d.ackph = 1'b1;
        if (!st_q.tx) begin
          case (st_q.pst)
            imsh_pkg::ps_dev : begin
              if (st_q.rxsh[7:3] == `IMSH_HS_CODE) begin
                st_d.hs  = 1'b1;
                st_d.pst = imsh_pkg::ps_ign;
              end else if (st_q.rxsh == `IMSH_RSV_ID) begin
                ack      = 1'b1;
                st_d.pst = imsh_pkg::ps_rsv_dev;
              end else if (match) begin
                ack      = 1'b1;
                // last address bit picks read or write
                st_d.pst = st_q.rxsh[0] ? imsh_pkg::ps_rd : imsh_pkg::ps_ah;
              end else begin
                st_d.pst = imsh_pkg::ps_ign;
              end
            end
            imsh_pkg::ps_ah : begin
              ack             = 1'b1;
              st_d.addr[15:8] = st_q.rxsh;
              st_d.pst        = imsh_pkg::ps_al;
            end
            imsh_pkg::ps_al : begin
              ack            = 1'b1;
              st_d.addr[7:0] = st_q.rxsh;
              st_d.pst       = imsh_pkg::ps_wr;
            end
            imsh_pkg::ps_wr : begin
              ack         = 1'b1;
              st_d.mem_we = 1'b1;
              st_d.waddr  = st_q.addr;
              st_d.wdata  = st_q.rxsh;
              st_d.addr   = st_q.addr + 16'h0001;
            end
            imsh_pkg::ps_rsv_dev : begin
              // device word in reserved frame, R/W ignored
              ack      = match;
              st_d.pst = match ? imsh_pkg::ps_rsv_wait : imsh_pkg::ps_ign;
            end
            imsh_pkg::ps_rsv_cmd : begin
              if (st_q.rxsh == `IMSH_SLEEP_CMD) begin
                // acknowledge then sleep after the ack bit
                ack             = 1'b1;
                st_d.sleep_pend = 1'b1;
                st_d.pst        = imsh_pkg::ps_ign;
              end else if (st_q.rxsh == `IMSH_ID_CMD) begin
                ack      = 1'b1;
                st_d.idx = 2'h0;
                st_d.pst = imsh_pkg::ps_id;
              end else begin
                st_d.pst = imsh_pkg::ps_ign;
              end
            end
            default : ack = 1'b0;
          endcase
        end
        // Released during the master's ack slot of a read byte
        st_d.sda_oe = ack;
      end else if (st_q.bitn == `IMSH_BIT_END) begin
        st_d.bitn   = 4'h0;
        st_d.ackph  = 1'b0;
        st_d.sda_oe = 1'b0;
        if (st_q.sleep_pend) begin
          // regulator stops once the ack bit is done
          st_d.sleep_pend = 1'b0;
          st_d.sleep      = 1'b1;
          st_d.reg_on     = 1'b0;
          st_d.pst        = imsh_pkg::ps_sleep;
        end else if ((st_q.pst == imsh_pkg::ps_rd || st_q.pst == imsh_pkg::ps_id)
                     && (!st_q.tx || !st_q.mack)) begin
          st_d.tx = 1'b1;
          if (st_q.pst == imsh_pkg::ps_rd) begin
            // next byte while the master acks
            st_d.txsh = mem[st_q.addr];
            st_d.addr = st_q.addr + 16'h0001;
          end else begin
            case (st_q.idx)
              2'h0    : st_d.txsh = ID_CODE[23:16];
              2'h1    : st_d.txsh = ID_CODE[15:8];
              default : st_d.txsh = ID_CODE[7:0];
            endcase
            // acked third byte restarts at first
            st_d.idx = (st_q.idx == `IMSH_ID_LAST) ? 2'h0 : st_q.idx + 2'h1;
          end
          st_d.sda_oe = ~st_d.txsh[7];
        end else if (st_q.tx) begin
          st_d.tx  = 1'b0;
          st_d.pst = imsh_pkg::ps_ign;
        end
      end else if (st_q.tx && st_q.bitn < `IMSH_BIT_ACK) begin
        st_d.sda_oe = ~st_q.txsh[7];
      end
    end

    // standby only after the recovery count
    if (st_q.pst == imsh_pkg::ps_recov) begin
      st_d.rec_cnt = st_q.rec_cnt + 16'h0001;
      if (st_q.rec_cnt == 16'(REC_CYC - 1)) begin
        st_d.sleep = 1'b0;
        st_d.pst   = imsh_pkg::ps_idle;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q        <= '0;
      st_q.scl_s  <= 3'h7;
      st_q.sda_s  <= 3'h7;
      st_q.scl_f  <= 1'b1;
      st_q.sda_f  <= 1'b1;
      st_q.pst    <= imsh_pkg::ps_idle;
      st_q.reg_on <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Array kept outside the struct; contents need no reset
  always_ff @(posedge core_clk) begin
    if (st_q.mem_we) begin
      mem[st_q.waddr] <= st_q.wdata;
    end
  end

  // ==========================================================
  // Outputs from flops, except the SDA data level tied low
  assign lnk.s_sda_o  = 1'b0;
  assign lnk.s_sda_oe = st_q.sda_oe;
  assign sleeping     = st_q.sleep;
  assign regulator_on = st_q.reg_on;
  assign hs_mode      = st_q.hs;

endmodule // imsh_dev
`default_nettype wire

/* logic/imsh_host.sv */
// Bus master end: issues read, write, HS, sleep, wake, ID and reset frames
`timescale 1ns/1ps
`default_nettype none
`include "imsh_consts.svh"
module imsh_host #(
  parameter int QTR_FM  = `IMSH_QTR_FM,
  parameter int QTR_HS  = `IMSH_QTR_HS,
  parameter int REC_CYC = `IMSH_REC_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  imsh_link.host                 lnk,
  input  wire logic              cmd_valid,
  input  wire imsh_pkg::imsh_cmd_t cmd_kind,
  input  wire logic [15:0]       cmd_addr,
  input  wire logic [7:0]        cmd_len,
  input  wire logic [2:0]        cmd_sel,
  output logic                   cmd_ready,
  output logic                   rd_valid,
  output logic [7:0]             rd_data,
  output logic                   done,
  output logic                   nack_err,
  output logic                   hs_active
);

  typedef struct packed {
    logic [2:0]          sda_s;
    logic                sda_f;
    logic                run;
    imsh_pkg::imsh_cmd_t cmd;
    logic [3:0]          sidx;
    logic [7:0]          rem;
    logic [15:0]         addr;
    logic [2:0]          sel;
    logic [7:0]          qcnt;
    logic [1:0]          ph;
    logic [3:0]          bitn;
    logic [7:0]          sh;
    logic                scl;
    logic                sda_oe;
    logic                hs;
    logic                err;
    logic                rd_valid;
    logic [7:0]          rd_data;
    logic                done;
    logic [15:0]         wcnt;
    logic [7:0]          wdat;
  } imsh_host_st_t;

  imsh_host_st_t     st_q;
  imsh_host_st_t     st_d;
  imsh_pkg::imsh_op_t op;
  logic              tick;
  logic              next;
  logic [7:0]        dev_w;

  // Fixed op lists; device word R/W bit is zero where it is ignored
  function automatic imsh_pkg::imsh_op_t op_at(input imsh_pkg::imsh_cmd_t c,
                                                 input logic [3:0] i,
                                                 input logic [7:0] dw,
                                                 input logic [15:0] a,
                                                 input logic [7:0] d);
    imsh_pkg::imsh_op_t o;
    o = '{imsh_pkg::op_end, 8'h00, 1'b1};
    case (c)
      imsh_pkg::cmd_read : begin
        case (i)
          4'h0, 4'h4 : o.kind = imsh_pkg::op_start;
          4'h1 : o = '{imsh_pkg::op_wr, dw, 1'b1};
          4'h2 : o = '{imsh_pkg::op_wr, a[15:8], 1'b1};
          4'h3 : o = '{imsh_pkg::op_wr, a[7:0], 1'b1};
          4'h5 : o = '{imsh_pkg::op_wr, dw | 8'h01, 1'b1};
          4'h6 : o.kind = imsh_pkg::op_rd;
          4'h7 : o.kind = imsh_pkg::op_stop;
          default : o.kind = imsh_pkg::op_end;
        endcase
      end
      imsh_pkg::cmd_hs : begin
        // entry code right after start, NACK expected
        case (i)
          4'h0 : o.kind = imsh_pkg::op_start;
          4'h1 : o = '{imsh_pkg::op_wr, `IMSH_HS_BYTE, 1'b0};
          default : o.kind = imsh_pkg::op_end;
        endcase
      end
      imsh_pkg::cmd_write : begin
        // Single byte store, so reads meet known data
        case (i)
          4'h0 : o.kind = imsh_pkg::op_start;
          4'h1 : o = '{imsh_pkg::op_wr, dw, 1'b1};
          4'h2 : o = '{imsh_pkg::op_wr, a[15:8], 1'b1};
          4'h3 : o = '{imsh_pkg::op_wr, a[7:0], 1'b1};
          4'h4 : o = '{imsh_pkg::op_wr, d, 1'b1};
          4'h5 : o.kind = imsh_pkg::op_stop;
          default : o.kind = imsh_pkg::op_end;
        endcase
      end
      imsh_pkg::cmd_wake : begin
        // start plus device word wakes it
        case (i)
          4'h0 : o.kind = imsh_pkg::op_start;
          4'h1 : o = '{imsh_pkg::op_wr, dw, 1'b0};
          4'h2 : o.kind = imsh_pkg::op_stop;
          4'h3 : o.kind = imsh_pkg::op_wait;
          default : o.kind = imsh_pkg::op_end;
        endcase
      end
      imsh_pkg::cmd_reset : begin
        // nine released clocks, then start and stop
        case (i)
          4'h0 : o.kind = imsh_pkg::op_clk9;
          4'h1 : o.kind = imsh_pkg::op_start;
          4'h2 : o.kind = imsh_pkg::op_stop;
          default : o.kind = imsh_pkg::op_end;
        endcase
      end
      default : begin
        // sleep and ID share the reserved frame
        case (i)
          4'h0, 4'h3 : o.kind = imsh_pkg::op_start;
          4'h1 : o = '{imsh_pkg::op_wr, `IMSH_RSV_ID, 1'b1};
          4'h2 : o = '{imsh_pkg::op_wr, dw, 1'b1};
          4'h4 : o = '{imsh_pkg::op_wr, (c == imsh_pkg::cmd_id) ? `IMSH_ID_CMD
                                         : `IMSH_SLEEP_CMD, 1'b1};
          4'h5 : o.kind = (c == imsh_pkg::cmd_id) ? imsh_pkg::op_rd : imsh_pkg::op_stop;
          4'h6 : o.kind = (c == imsh_pkg::cmd_id) ? imsh_pkg::op_stop : imsh_pkg::op_end;
          default : o.kind = imsh_pkg::op_end;
        endcase
      end
    endcase
    return o;
  endfunction

  assign dev_w = {`IMSH_DEV_TYPE, st_q.sel, 1'b0};
  assign op    = op_at(st_q.cmd, st_q.sidx, dev_w, st_q.addr, st_q.wdat);

  // ==========================================================
  // Sequencer and bit engine
  always_comb begin
    st_d          = st_q;
    st_d.rd_valid = 1'b0;
    st_d.done     = 1'b0;
    next          = 1'b0;
    st_d.sda_s    = {st_q.sda_s[1:0], lnk.sda};
    if (st_q.sda_s[1] == st_q.sda_s[2]) begin
      st_d.sda_f = st_q.sda_s[2];
    end
    // quarter period follows the current speed
    tick = st_q.qcnt == 8'(((st_q.hs ? QTR_HS : QTR_FM) - 1));
    st_d.qcnt = (tick || !st_q.run) ? 8'h00 : st_q.qcnt + 8'h01;

    if (!st_q.run) begin
      if (cmd_valid) begin
        st_d.run  = 1'b1;
        st_d.cmd  = cmd_kind;
        st_d.addr = cmd_addr;
        st_d.sel  = cmd_sel;
        st_d.rem  = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
        st_d.wdat = cmd_len;  // Data byte of a write
        st_d.sidx = 4'h0;
        st_d.ph   = 2'h0;
        st_d.bitn = 4'h0;
        st_d.err  = 1'b0;
      end
    end else if (op.kind == imsh_pkg::op_end) begin
      st_d.run  = 1'b0;
      st_d.done = 1'b1;
    end else if (op.kind == imsh_pkg::op_wait) begin
      st_d.wcnt = st_q.wcnt + 16'h0001;
      if (st_q.wcnt == 16'(REC_CYC - 1)) begin
        st_d.wcnt = 16'h0000;
        next      = 1'b1;
      end
    end else if (tick) begin
      st_d.ph = st_q.ph + 2'h1;
      case (op.kind)
        imsh_pkg::op_start : begin
          case (st_q.ph)
            2'h0 : st_d.sda_oe = 1'b0;
            2'h1 : st_d.scl = 1'b1;
            2'h2 : st_d.sda_oe = 1'b1;
            default : begin
              st_d.scl = 1'b0;
              next     = 1'b1;
            end
          endcase
        end
        imsh_pkg::op_stop : begin
          case (st_q.ph)
            2'h0 : st_d.sda_oe = 1'b1;
            2'h1 : st_d.scl = 1'b1;
            2'h2 : st_d.sda_oe = 1'b0;
            default : begin
              st_d.hs = 1'b0;
              next    = 1'b1;
            end
          endcase
        end
        default : begin
          case (st_q.ph)
            2'h0 : begin
              // SDA is only pulled low or released
              if (op.kind == imsh_pkg::op_wr) begin
                if (st_q.bitn == 4'h0) begin
                  st_d.sh = op.data;
                end
                st_d.sda_oe = (st_q.bitn < `IMSH_BIT_ACK) && !st_d.sh[7];
              end else if (op.kind == imsh_pkg::op_rd) begin
                // last byte gets NACK, for read and ID
                st_d.sda_oe = (st_q.bitn == `IMSH_BIT_ACK) && (st_q.rem != 8'h01);
              end else begin
                st_d.sda_oe = 1'b0;
              end
            end
            2'h1 : st_d.scl = 1'b1;
            2'h2 : begin
              if (op.kind == imsh_pkg::op_wr && st_q.bitn == `IMSH_BIT_ACK) begin
                // NACK flagged so the user can retry
                if (op.ack_exp && st_q.sda_f) begin
                  st_d.err = 1'b1;
                end
                // switch to high speed after the NACK
                if (st_q.cmd == imsh_pkg::cmd_hs && st_q.sda_f) begin
                  st_d.hs = 1'b1;
                end
              end else if (op.kind == imsh_pkg::op_rd && st_q.bitn < `IMSH_BIT_ACK) begin
                st_d.sh = {st_q.sh[6:0], st_q.sda_f};
              end
            end
            default : begin
              st_d.scl  = 1'b0;
              st_d.bitn = st_q.bitn + 4'h1;
              if (op.kind == imsh_pkg::op_wr) begin
                st_d.sh = {st_q.sh[6:0], 1'b0};
              end
              if (st_q.bitn == `IMSH_BIT_ACK) begin
                st_d.bitn = 4'h0;
                if (op.kind == imsh_pkg::op_rd) begin
                  st_d.rd_valid = 1'b1;
                  st_d.rd_data  = st_q.sh;
                  st_d.rem      = st_q.rem - 8'h01;
                  next          = st_q.rem == 8'h01;
                end else begin
                  next = 1'b1;
                end
              end
            end
          endcase
        end
      endcase
    end
    if (next) begin
      st_d.sidx = st_q.sidx + 4'h1;
      st_d.ph   = 2'h0;
      st_d.bitn = 4'h0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q       <= '0;
      st_q.sda_s <= 3'h7;
      st_q.sda_f <= 1'b1;
      st_q.scl   <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign lnk.scl      = st_q.scl;
  assign lnk.m_sda_o  = 1'b0;
  assign lnk.m_sda_oe = st_q.sda_oe;
  assign cmd_ready    = ~st_q.run;
  assign rd_valid     = st_q.rd_valid;
  assign rd_data      = st_q.rd_data;
  assign done         = st_q.done;
  assign nack_err     = st_q.err;
  assign hs_active    = st_q.hs;

endmodule // imsh_host
`default_nettype wire

/* sim/imsh_assertions.sv */
// Link checker for the memory end and the master end
`timescale 1ns/1ps
`default_nettype none
module imsh_assertions #(parameter int REC_CYC = 250) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic sleeping,
  input wire logic regulator_on,
  input wire logic hs_mode
);
  // Slack covers the pin sync lag
  localparam int REC_LO = REC_CYC - 2;
  localparam int REC_HI = REC_CYC + 4;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Wire and mode relations
  property p_odrain; (m_sda_oe |-> !m_sda_o) and (s_sda_oe |-> !s_sda_o); endproperty
  a_odrain: assert property (p_odrain) else $error("sda driven high");
  property p_drv_low; $rose(s_sda_oe) |-> !scl; endproperty
  a_drv_low: assert property (p_drv_low) else $error("slave drive with scl high");
  property p_hs_exit; scl && $rose(sda) |-> ##[1:12] !hs_mode; endproperty
  a_hs_exit: assert property (p_hs_exit) else $error("hs kept after stop");
  property p_hs_nack; $rose(hs_mode) |-> !s_sda_oe [*8]; endproperty
  a_hs_nack: assert property (p_hs_nack) else $error("hs code acked");
  property p_reg_off; $fell(regulator_on) |-> sleeping; endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulator off awake");
  property p_off_quiet; !regulator_on |-> !s_sda_oe; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("drive while asleep");
  property p_wake_rise; $rose(regulator_on) |-> scl && sleeping; endproperty
  a_wake_rise: assert property (p_wake_rise) else $error("recovery off scl rise");
  property p_recov; $rose(regulator_on) |-> sleeping ##[REC_LO:REC_HI] !sleeping; endproperty
  a_recov: assert property (p_recov) else $error("recovery time wrong");
endmodule // imsh_assertions
`default_nettype wire

/* sim/i2c_memory_seqread_hs_sleep_id_bench.sv */
// Bench joining both link ends
`timescale 1ns/1ps
`default_nettype none
module i2c_memory_seqread_hs_sleep_id_bench;
  localparam logic [23:0] ID = 24'ha5c3_96; // Arbitrary value
  logic                core_clk = 1'b0;
  logic                rstn = 1'b0;
  logic                cmd_valid = 1'b0;
  imsh_pkg::imsh_cmd_t cmd_kind = imsh_pkg::cmd_read;
  logic [15:0]         cmd_addr = 16'h0000;
  logic [7:0]          cmd_len = 8'h01;
  logic [2:0]          cmd_sel = 3'h5;
  logic [2:0]          dev_sel = 3'h5;
  logic                cmd_ready, rd_valid, done, nack_err, hs_active;
  logic                sleeping, regulator_on, hs_mode;
  logic [7:0]          rd_data;
  logic [7:0]          got [$];
  int                  fails = 0;
  int                  samples_checked = 0;
  imsh_link lnk ();
  imsh_dev #(.REC_CYC(20), .ID_CODE(ID)) i_imsh_dev (.core_clk(core_clk), .rstn(rstn),
    .lnk(lnk), .chip_select_bit2(dev_sel[2]), .chip_select_bit1(dev_sel[1]),
    .chip_select_bit0(dev_sel[0]),
    .sleeping(sleeping), .regulator_on(regulator_on), .hs_mode(hs_mode));
  // Short quarters keep the run brief
  imsh_host #(.QTR_FM(16), .QTR_HS(10), .REC_CYC(20)) i_imsh_host (.core_clk(core_clk),
    .rstn(rstn), .lnk(lnk), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_sel(cmd_sel), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .nack_err(nack_err), .hs_active(hs_active));
  imsh_assertions #(.REC_CYC(20)) i_imsh_assertions (.core_clk(core_clk), .rstn(rstn),
    .scl(lnk.scl), .sda(lnk.sda), .m_sda_o(lnk.m_sda_o), .m_sda_oe(lnk.m_sda_oe),
    .s_sda_o(lnk.s_sda_o), .s_sda_oe(lnk.s_sda_oe), .sleeping(sleeping),
    .regulator_on(regulator_on), .hs_mode(hs_mode));
  // Clock and read byte capture
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (rd_valid === 1'b1) got.push_back(rd_data);
  task automatic final_report();
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One command, waited on under a bound
  task automatic run(input imsh_pkg::imsh_cmd_t k, input logic [15:0] a,
                     input logic [7:0] n, input logic [2:0] s);
    int i;
    got.delete();
    @(posedge core_clk);
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_len <= n;
    cmd_sel <= s;
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 30000 && done !== 1'b1; i++) @(negedge core_clk);
    if (i == 30000) begin
      fails++;
      final_report();
    end
  endtask
  task automatic t_id(input logic [7:0] n);
    run(imsh_pkg::cmd_id, 16'h0000, n, 3'h5);
    chk({got[0], got[1], got[2]}, ID);
    chk(nack_err, 1'b0);
    if (n > 8'h03) chk(got[3], ID[23:16]);
  endtask
  task automatic t_read();
    // Known bytes on both sides of the wrap point
    for (int j = 0; j < 3; j++)
      run(imsh_pkg::cmd_write, 16'hffff + 16'(j), 8'h3c + 8'(j), 3'h5);
    run(imsh_pkg::cmd_read, 16'hffff, 8'h03, 3'h5);
    chk(24'(got.size()), 24'h00_0003);
    chk({got[0], got[1], got[2]}, 24'h3c_3d3e);
    chk(nack_err, 1'b0);
    run(imsh_pkg::cmd_read, 16'h0010, 8'h01, 3'h2);
    chk(nack_err, 1'b1);
    // Select pins moved: the same word now matches
    @(posedge core_clk) dev_sel <= 3'h2;
    run(imsh_pkg::cmd_read, 16'h0000, 8'h01, 3'h2);
    chk({nack_err, got[0]}, 9'h03d);
    @(posedge core_clk) dev_sel <= 3'h5;
  endtask
  task automatic t_hs();
    run(imsh_pkg::cmd_hs, 16'h0000, 8'h01, 3'h5);
    chk({hs_active, hs_mode}, 2'b11);
    t_id(8'h03);
    chk(hs_mode, 1'b0);
  endtask
  task automatic t_sleep();
    run(imsh_pkg::cmd_sleep, 16'h0000, 8'h01, 3'h5);
    chk({sleeping, regulator_on}, 2'b10);
    run(imsh_pkg::cmd_wake, 16'h0000, 8'h01, 3'h5);
    chk({sleeping, regulator_on}, 2'b01);
    run(imsh_pkg::cmd_reset, 16'h0000, 8'h01, 3'h5);
    chk({cmd_ready, sleeping, hs_mode}, 3'b100);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_id(8'h04);
    t_read();
    t_hs();
    t_sleep();
    t_id(8'h03);
    final_report();
  end
endmodule // i2c_memory_seqread_hs_sleep_id_bench
`default_nettype wire
